// File: i2c_tmo_consts.svh
`ifndef I2C_TMO_CONSTS_SVH
`define I2C_TMO_CONSTS_SVH

// ********************************
// Timing
// ********************************
// Longest legal transaction, in milliseconds
`define TMO_TIME_MS 1000
// Supervisor clock rate in hertz
`define CLK_FREQ_HZ 100000000
// Cycles in one timeout interval; 64 bits because the product passes 2^31
`define TMO_CYCLES (64'd`TMO_TIME_MS * 64'd`CLK_FREQ_HZ / 64'd1000)
// Counter width, enough for the default interval
`define TMO_CNT_W 27

// ********************************
// Protocol positions
// ********************************
`define BIT_ACK 4'h8
`define BIT_FIRST 4'h0
`define BYTE_SLAVE 2'h0
`define BYTE_POINTER 2'h1
`define BYTE_DATA 2'h2
`define PTR_STALL 8'h00
`define PTR_RESET 8'h00
`define SHIFT_RESET 8'h00
`define CNT_ZERO 27'h0

`endif

// File: i2c_tmo_pkg.sv
package i2c_tmo_pkg;

	// Sampled bus lines travel together
	typedef struct packed {
		logic scl;
		logic sda;
	} line_s;

	// Supervisor states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACTIVE,
		ST_ABORT
	} tmo_state_e;

endpackage

// File: i2c_tmo_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser plus one stage of history for edge finding
module i2c_tmo_sync import i2c_tmo_pkg::*; (
	input wire logic CLK, // system clock
	input wire logic RSTN, // synchronous reset, active low
	input wire line_s PIN, // raw bus lines
	output line_s SYNC, // synchronised lines
	output line_s PREV // synchronised lines one cycle older
);
	line_s meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;

	// Only the second stage reads the first; idle bus level is high
	always_comb begin
		meta_d = PIN;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			meta_q <= '1;
			sync_q <= '1;
			prev_q <= '1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	assign SYNC = sync_q;
	assign PREV = prev_q;
endmodule // i2c_tmo_sync

`default_nettype wire

// File: i2c_bus_timeout.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2c_tmo_consts.svh"

module i2c_bus_timeout import i2c_tmo_pkg::*; #(
	parameter int unsigned TMO_CYCLES = 32'(`TMO_CYCLES), // cycles in one second
	parameter int unsigned CNT_W = `TMO_CNT_W // timeout counter width
) (
	input wire logic CLK, // internal oscillator clock
	input wire logic RSTN, // synchronous reset, active low
	input wire logic SCL_IN, // bus clock pin level
	input wire logic SDA_IN, // bus data pin level
	input wire logic CORE_SDA_LOW, // slave core wants data line low
	input wire logic CLOCK_HALT, // clock-halt control bit
	output logic SDA_OUT, // data pin output value, always low
	output logic SDA_OE_N, // data pin enable, low while driving
	output logic BUSY, // transaction in progress
	output logic ABORT, // one-cycle pulse on timeout abort
	output logic HELD // stalled acknowledge, timeout inhibited
);
	// ********************************
	// Pin sampling and bus conditions
	// ********************************
	line_s pin, cur, prv;
	logic start_c, stop_c, scl_rise, scl_fall;

	assign pin = '{scl: SCL_IN, sda: SDA_IN};

	i2c_tmo_sync u_sync (
		.CLK(CLK),
		.RSTN(RSTN),
		.PIN(pin),
		.SYNC(cur),
		.PREV(prv)
	);

	// Data edges while the clock stays high mark START and STOP
	always_comb begin
		start_c = cur.scl & prv.scl & prv.sda & ~cur.sda;
		stop_c = cur.scl & prv.scl & ~prv.sda & cur.sda;
		scl_rise = cur.scl & ~prv.scl;
		scl_fall = ~cur.scl & prv.scl;
	end

	// ********************************
	// Bit and byte tracking
	// ********************************
	logic [3:0] bit_q, bit_d;
	logic [1:0] byte_q, byte_d;
	logic [7:0] shift_q, shift_d, ptr_q, ptr_d;
	logic rd_q, rd_d;
	logic skip_q, skip_d;
	logic stall_c;

	// Eighth data clock of a byte has just ended
	function automatic logic last_data_bit(input logic [3:0] b);
		return b == `BIT_ACK - 4'h1;
	endfunction

	// Follows the frame only far enough to find the write target
	always_comb begin
		bit_d = bit_q;
		byte_d = byte_q;
		shift_d = shift_q;
		ptr_d = ptr_q;
		rd_d = rd_q;
		skip_d = skip_q;
		if (start_c) begin
			bit_d = `BIT_FIRST;
			byte_d = `BYTE_SLAVE;
			skip_d = 1'b1;
		end else if (scl_rise && bit_q != `BIT_ACK) begin
			shift_d = {shift_q[6:0], cur.sda};
		end else if (scl_fall && skip_q) begin
			// Clock fall that closes a START carries no data bit; counting it skews every byte
			skip_d = 1'b0;
		end else if (scl_fall) begin
			if (bit_q == `BIT_ACK) begin
				bit_d = `BIT_FIRST;
				if (byte_q == `BYTE_DATA)
					ptr_d = ptr_q + 8'h01; // auto increment
				else
					byte_d = byte_q + 2'h1;
			end else begin
				bit_d = bit_q + 4'h1;
				if (last_data_bit(bit_q) && byte_q == `BYTE_SLAVE)
					rd_d = shift_q[0];
				if (last_data_bit(bit_q) && byte_q == `BYTE_POINTER && !rd_q)
					ptr_d = shift_q;
			end
		end
	end

	// Acknowledge of a data byte written to address 00h
	assign stall_c = (bit_q == `BIT_ACK) && (byte_q == `BYTE_DATA) && !rd_q
		&& (ptr_q == `PTR_STALL);

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			bit_q <= `BIT_FIRST;
			byte_q <= `BYTE_SLAVE;
			shift_q <= `SHIFT_RESET;
			ptr_q <= `PTR_RESET;
			rd_q <= 1'b0;
			skip_q <= 1'b0;
		end else begin
			bit_q <= bit_d;
			byte_q <= byte_d;
			shift_q <= shift_d;
			ptr_q <= ptr_d;
			rd_q <= rd_d;
			skip_q <= skip_d;
		end
	end

	// ********************************
	// Timeout supervisor
	// ********************************
	tmo_state_e state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic held_q, held_d, expired_c, abort_c;
	logic oe_n_q, oe_n_d, abort_q;
	logic busy_q, busy_d;

	assign expired_c = cnt_q >= CNT_W'(TMO_CYCLES);
	// Halt bit and a held stall both veto the abort; a START or STOP in the same cycle wins
	assign abort_c = (state_q == ST_ACTIVE) && expired_c && !CLOCK_HALT
		&& !held_q && !stall_c && !start_c && !stop_c;

	// Counter saturates, so a late halt release aborts at once
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		held_d = held_q;
		if (start_c || stop_c)
			cnt_d = `CNT_ZERO;
		else if (state_q == ST_ACTIVE && !expired_c)
			cnt_d = cnt_q + CNT_W'(1);
		if (stop_c)
			held_d = 1'b0;
		else if (stall_c && state_q == ST_ACTIVE)
			held_d = 1'b1;
		unique case (state_q)
			ST_IDLE: begin
				if (start_c)
					state_d = ST_ACTIVE;
			end
			ST_ACTIVE: begin
				if (stop_c)
					state_d = ST_IDLE;
				else if (abort_c)
					state_d = ST_ABORT;
			end
			ST_ABORT: begin
				if (stop_c)
					state_d = ST_IDLE;
				else if (start_c)
					state_d = ST_ACTIVE;
			end
		endcase
		// Released after abort; core drive passes through otherwise
		oe_n_d = !(CORE_SDA_LOW && state_d != ST_ABORT);
		// Busy flag registered so the pin comes straight from a flop
		busy_d = (state_d == ST_ACTIVE);
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			state_q <= ST_IDLE;
			cnt_q <= `CNT_ZERO;
			held_q <= 1'b0;
			oe_n_q <= 1'b1;
			abort_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			held_q <= held_d;
			oe_n_q <= oe_n_d;
			abort_q <= abort_c;
			busy_q <= busy_d;
		end
	end

	// Outputs come straight from flops, except SDA_OUT, which is tied low
	assign SDA_OUT = 1'b0;
	assign SDA_OE_N = oe_n_q;
	assign BUSY = busy_q;
	assign ABORT = abort_q;
	assign HELD = held_q;

	// ********************************
	// Checks
	// ********************************
	AST_ABORT_RELEASES: assert property (@(posedge CLK) disable iff (!RSTN)
		abort_c |=> (state_q == ST_ABORT) && SDA_OE_N && ABORT)
		else $error("timeout did not release data line");
	AST_START_CLEARS: assert property (@(posedge CLK) disable iff (!RSTN)
		start_c |=> (state_q == ST_ACTIVE) && (cnt_q == `CNT_ZERO))
		else $error("START did not open a cleared interval");
	AST_STOP_CLEARS: assert property (@(posedge CLK) disable iff (!RSTN)
		stop_c |=> (cnt_q == `CNT_ZERO) && (state_q == ST_IDLE) ##1 (cnt_q == `CNT_ZERO))
		else $error("STOP did not clear the counter");
	AST_STALL_KEEPS_LOW: assert property (@(posedge CLK) disable iff (!RSTN)
		(stall_c && CORE_SDA_LOW && state_q == ST_ACTIVE && !stop_c) |=> !SDA_OE_N)
		else $error("stalled acknowledge released the data line");
	AST_HALT_NO_ABORT: assert property (@(posedge CLK) disable iff (!RSTN)
		(CLOCK_HALT && state_q == ST_ACTIVE) |=> (state_q != ST_ABORT) && !ABORT)
		else $error("abort while clock halt set");
	AST_HELD_TILL_STOP: assert property (@(posedge CLK) disable iff (!RSTN)
		(held_q && !stop_c) |=> held_q && (state_q != ST_ABORT))
		else $error("held transaction ended without STOP");

	AST_ABORT_PULSE: assert property (@(posedge CLK) disable iff (!RSTN)
		ABORT |=> !ABORT)
		else $error("abort pulse longer than one cycle");
	AST_IDLE_NO_COUNT: assert property (@(posedge CLK) disable iff (!RSTN)
		(state_q == ST_IDLE && !start_c) |=> $stable(cnt_q))
		else $error("counter moved outside a transaction");

	COV_ABORT: cover property (@(posedge CLK) disable iff (!RSTN) ABORT);
	COV_HELD_EXPIRED: cover property (@(posedge CLK) disable iff (!RSTN) held_q && expired_c);
	COV_HALT_EXPIRED: cover property (@(posedge CLK) disable iff (!RSTN)
		CLOCK_HALT && expired_c && state_q == ST_ACTIVE);
endmodule // i2c_bus_timeout

`default_nettype wire

// File: i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// Bus master model, 160 ns bit time
// ********************************
module i2c_master_model (
	output logic SCL, // bus clock
	output logic SDA_LOW, // pulls data line low
	output logic ACK_WIN // ninth clock window
);
	// Clock stands high between frames; data released to pull-up
	initial begin
		SCL = 1'b1;
		SDA_LOW = 1'b0;
		ACK_WIN = 1'b0;
	end
	// Data falls while clock high; also serves as repeated start
	task automatic start();
		SDA_LOW = 1'b0;
		#40 SCL = 1'b1;
		#80 SDA_LOW = 1'b1;
		#80 SCL = 1'b0;
	endtask
	// Data rises while clock high, the only way to close
	task automatic stop();
		SDA_LOW = 1'b1;
		#40 SCL = 1'b1;
		#80 SDA_LOW = 1'b0;
		#80;
	endtask
	// MSB first, data moves only while clock low; stall before ninth clock
	task automatic wbyte(input logic [7:0] b, input int stall);
		for (int i = 7; i >= 0; i--) begin
			SDA_LOW = ~b[i];
			#40 SCL = 1'b1;
			#80 SCL = 1'b0;
			#40;
		end
		SDA_LOW = 1'b0;
		ACK_WIN = 1'b1;
		#(stall + 40) SCL = 1'b1;
		#80 SCL = 1'b0; // ninth clock lowered ends the ack
		#40 ACK_WIN = 1'b0;
	endtask
endmodule // i2c_master_model
`default_nettype wire

// File: i2c_bus_timeout_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// Timeout supervisor bench
// ********************************
module i2c_bus_timeout_tb;
	localparam int TMO = 600;
	logic CLK = 1'b0, RSTN = 1'b0, CORE_SDA_LOW = 1'b0, CLOCK_HALT = 1'b0, core_hold = 1'b0;
	logic scl, mst_low, ack_win, sda, sda_out, sda_oe_n, busy, abort, held;
	logic [7:0] ptr;
	int bad_count = 0, tests_run = 0, aborts = 0, base, n;
	always #5 CLK = ~CLK;
	// Wired-AND line; pull-up wins when nobody drives
	assign sda = ~(mst_low | ~sda_oe_n);
	// Core acks every ninth clock, or pulls low when told to
	always @(negedge CLK) CORE_SDA_LOW <= core_hold | ack_win;
	always @(posedge CLK) if (abort === 1'b1) aborts <= aborts + 1;
	i2c_master_model i_mst (.SCL(scl), .SDA_LOW(mst_low), .ACK_WIN(ack_win));
	i2c_bus_timeout #(.TMO_CYCLES(TMO)) i_dut (.CLK(CLK), .RSTN(RSTN), .SCL_IN(scl),
		.SDA_IN(sda), .CORE_SDA_LOW(CORE_SDA_LOW), .CLOCK_HALT(CLOCK_HALT),
		.SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .BUSY(busy), .ABORT(abort), .HELD(held));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	// Stall at pointer 00h holds the line low; any other pointer times out once
	function automatic logic [9:0] stall_exp(input logic [7:0] p);
		return (p == 8'h00) ? 10'h200 : 10'h101;
	endfunction
	task automatic cyc(input int k);
		repeat (k) @(negedge CLK);
	endtask
	// Stop, then realign to the falling edge
	task automatic end_frame();
		i_mst.stop();
		cyc(8);
	endtask
	task automatic print_verdict();
		if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Main sequence
	initial begin
		void'($urandom(32'hf7c5));
		cyc(4);
		RSTN = 1'b1;
		cyc(4);
		// Short write well inside the interval
		i_mst.start();
		cyc(8);
		chk(busy, 1'b1);
		chk(sda_out, 1'b0);
		i_mst.wbyte(8'ha0, 0);
		i_mst.wbyte(8'($urandom), 0);
		end_frame();
		chk({busy, 8'(aborts)}, 9'h000);
		// Hung frame with core pulling low: aborted and released
		// Core pulls low only after START; earlier its own pull would make the START
		i_mst.start();
		core_hold = 1'b1;
		cyc(8);
		chk(sda_oe_n, 1'b0);
		n = 0;
		while (abort !== 1'b1 && n < 2 * TMO) begin
			cyc(1);
			n++;
		end
		chk(n >= TMO - 20 && n <= TMO, 1'b1);
		if (n >= 2 * TMO) print_verdict();
		cyc(2);
		chk({busy, sda_oe_n}, 2'b01);
		core_hold = 1'b0;
		end_frame();
		// Repeated start clears the count
		base = aborts;
		i_mst.start();
		cyc(TMO * 2 / 3);
		i_mst.start();
		cyc(TMO * 2 / 3);
		chk({busy, 8'(aborts - base)}, 9'h100);
		end_frame();
		// Halt bit suppresses the abort entirely
		CLOCK_HALT = 1'b1;
		i_mst.start();
		cyc(TMO + 100);
		chk({busy, 8'(aborts - base)}, 9'h100);
		end_frame();
		CLOCK_HALT = 1'b0;
		// Stalled data ack: pointer 00 holds low, other pointers time out
		for (int k = 0; k < 2; k++) begin
			ptr = k ? 8'(1 + $urandom_range(254)) : 8'h00;
			base = aborts;
			i_mst.start();
			i_mst.wbyte(8'ha0, 0);
			i_mst.wbyte(ptr, 0);
			fork
				i_mst.wbyte(8'($urandom), 20 * TMO);
				begin
					#(15 * TMO);
					@(negedge CLK);
					chk({held, sda_oe_n, 8'(aborts - base)}, stall_exp(ptr));
				end
			join
			end_frame();
			chk({busy, held}, 2'b00);
		end
		print_verdict();
	end
endmodule // i2c_bus_timeout_tb
`default_nettype wire
